// *** rtl/fsc_regs.svh ***
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH

// register offsets (16-bit register words)
`define FSC_CTRL_ADR      16'h0170
`define FSC_NMUL_ADR      16'h0171
`define FSC_THETA_ADR     16'h0172
`define FSC_LAMBDA_ADR    16'h0173
`define FSC_SYNC_ADR      16'h0174
`define FSC_FRC_ADR       16'h0175
`define FSC_INTEG_ADR     16'h0176
`define FSC_INTEG_RB_ADR  16'h0177
`define FSC_SS_ADR        16'h0178
`define FSC_GPIO_ADR      16'h0179
`define FSC_STAT_ADR      16'h017A
`define FSC_SRC_ADR       16'h017B
`define FSC_TUNE_ADR      16'h01A7

// field positions
`define FSC_CTRL_EN       0
`define FSC_CTRL_FR       1
`define FSC_CTRL_UPD      2
`define FSC_INTEG_UPD     0
`define FSC_INTEG_VALID   1
`define FSC_TUNE_BW       0
`define FSC_TUNE_GAIN_LO  2

// reset values
`define FSC_FRC_RST       16'h0000
`define FSC_GAIN_RST      4'h0
`define FSC_BW_RST        1'b1
`define FSC_SRC_RST       4'h0
`define FSC_SYNC_DEN      17'h10000

// timing: debounce tick near 32 kHz, clock 4 ns
`define FSC_TICK_NS       31250
`define FSC_CLK_NS        4
`define FSC_TICK_CYC      (`FSC_TICK_NS / `FSC_CLK_NS)
`define FSC_DB_TICKS      4

`endif

// *** rtl/fsc_pkg.sv ***
package fsc_pkg;

   typedef enum logic [2:0] {
      FSC_IDLE = 3'b001,
      FSC_REF  = 3'b010,
      FSC_FREE = 3'b100
   } fsc_state_t;

   typedef enum logic [1:0] {
      FSC_SS_OFF  = 2'h0,
      FSC_SS_TRI  = 2'h1,
      FSC_SS_ZERO_MEAN_FREQ_MODULATION = 2'h2,
      FSC_SS_DITH = 2'h3
   } fsc_ss_t;

   typedef enum logic [1:0] {
      FSC_GP_CLKOK = 2'h0,
      FSC_GP_LOCK  = 2'h1,
      FSC_GP_CLK   = 2'h2,
      FSC_GP_LOW   = 2'h3
   } fsc_gp_t;

   typedef struct packed {
      fsc_state_t  st;
      logic        ran;
      logic [1:0]  ref_s;
      logic [1:0]  iv_s;
      logic        en;
      logic        fr;
      logic        sync_en;
      logic [15:0] n_sh;
      logic [15:0] th_sh;
      logic [15:0] lam;
      logic [15:0] n_eff;
      logic [15:0] th_eff;
      logic [15:0] frc;
      logic [3:0]  src;
      logic [3:0]  gain;
      logic        bw;
      fsc_ss_t     ss_mode;
      logic [3:0]  ss_amp;
      logic [3:0]  ss_freq;
      fsc_gp_t     gp_sel;
      logic        ld;
      logic [15:0] ld_val;
      logic [15:0] div;
      logic        tick;
      logic [15:0] rdata;
      logic        rvalid;
   } fsc_st_t;

   typedef struct packed {
      logic [1:0] raw_s;
      logic [1:0] on_s;
      logic [7:0] cnt;
      logic       clean;
   } fsc_db_st_t;

endpackage : fsc_pkg

// *** rtl/fsc_db_if.sv ***
`timescale 1ns/100ps
interface fsc_db_if;
   logic tick;
   logic clk_on;
   logic raw;
   logic clean;
   modport ctrl (output tick, output clk_on, output raw, input clean);
   modport deb  (input tick, input clk_on, input raw, output clean);
endinterface : fsc_db_if

// *** rtl/fsc_debounce.sv ***
`timescale 1ns/100ps
`include "fsc_regs.svh"
module fsc_debounce #(
   parameter int DB_TICKS = `FSC_DB_TICKS
)(
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   fsc_db_if.deb     db
);
   fsc_pkg::fsc_db_st_t q;
   fsc_pkg::fsc_db_st_t n;

   assign db.clean = q.clean;

   always_comb begin
      n = q;
      n.raw_s = {q.raw_s[0], db.raw};
      n.on_s  = {q.on_s[0], db.clk_on};
      // no running slow clock means the status never moves
      if (db.tick && q.on_s[1]) begin
         if (q.raw_s[1] == q.clean) begin
            n.cnt = 8'h00;
         end else if (q.cnt == 8'(DB_TICKS - 1)) begin
            n.clean = q.raw_s[1];
            n.cnt   = 8'h00;
         end else begin
            n.cnt = q.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end
endmodule : fsc_debounce

// *** rtl/fsc_ctrl.sv ***
// Operation
// - denominator ignored while synchroniser enabled
// - four-bit synchroniser source, reserved codes refused
// - gain is two to code, saturating 256
// - bandwidth bit: 0 wide, 1 narrow, reset 1
// - free-run halts feedback correction
// - entering free-run keeps prior frequency
// - lost reference keeps loop running unreferenced
// - free-run clear relocks when reference returns
// - integrator strobe loads forced value in free-run
// - cold start in free-run uses reset value
// - live integrator readable, valid flag reported in free-run
// - per-loop spread spectrum mode, amplitude, rate
// - clock-OK and lock statuses provided
// - debounced statuses need running slow clock
// - pin statuses undebounced, need no clock
// - loop-derived clock selectable onto pin
// - multiplier changes apply on update strobe while enabled, at once while disabled
`timescale 1ns/100ps
`include "fsc_regs.svh"
module fsc_ctrl #(
   parameter int TICK_CYCLES = `FSC_TICK_CYC,
   parameter int DB_TICKS    = `FSC_DB_TICKS
)(
   input  wire logic        i_clock,
   input  wire logic        i_sys_rst,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [15:0] i_reg_addr,
   input  wire logic [15:0] i_reg_wdata,
   output wire logic [15:0] o_reg_rdata,
   output wire logic        o_reg_rvalid,
   input  wire logic        i_ref_present,
   input  wire logic        i_loop_clk_ok,
   input  wire logic        i_loop_lock,
   input  wire logic        i_loop_clk,
   input  wire logic        i_integ_valid,
   input  wire logic [15:0] i_integ_live,
   input  wire logic        i_slow_clk_on,
   output wire logic        o_loop_enable,
   output wire logic        o_feedback_on,
   output wire logic        o_integ_load,
   output wire logic [15:0] o_integ_value,
   output wire logic [15:0] o_int_mult,
   output wire logic [15:0] o_frac_num,
   output wire logic [16:0] o_frac_den,
   output wire logic        o_sync_enable,
   output wire logic [3:0]  o_sync_src,
   output wire logic [8:0]  o_sync_gain,
   output wire logic        o_sync_narrow_bw,
   output wire logic [1:0]  o_ss_mode,
   output wire logic [3:0]  o_ss_amp,
   output wire logic [3:0]  o_ss_freq,
   output wire logic        o_clk_ok_db,
   output wire logic        o_lock_db,
   output wire logic        o_gpio_out
);
   fsc_pkg::fsc_st_t q;
   fsc_pkg::fsc_st_t n;
   logic             mult_upd;
   logic             integ_upd;
   logic             gpio_mux;
   logic [8:0]       gain_dec;

   fsc_db_if okb ();
   fsc_db_if lkb ();

   function automatic logic src_ok(input logic [3:0] c);
      case (c)
         4'h0:    src_ok = 1'b1;
         4'h1:    src_ok = 1'b1;
         4'h4:    src_ok = 1'b1;
         4'h5:    src_ok = 1'b1;
         4'h8:    src_ok = 1'b1;
         4'h9:    src_ok = 1'b1;
         4'hA:    src_ok = 1'b1;
         4'hC:    src_ok = 1'b1;
         4'hD:    src_ok = 1'b1;
         4'hE:    src_ok = 1'b1;
         default: src_ok = 1'b0;
      endcase
   endfunction : src_ok

   assign okb.tick   = q.tick;
   assign okb.clk_on = i_slow_clk_on;
   assign okb.raw    = i_loop_clk_ok;
   assign lkb.tick   = q.tick;
   assign lkb.clk_on = i_slow_clk_on;
   assign lkb.raw    = i_loop_lock;

   fsc_debounce #(
      .DB_TICKS (DB_TICKS)
   ) u_ok_db (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .db        (okb)
   );

   fsc_debounce #(
      .DB_TICKS (DB_TICKS)
   ) u_lock_db (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .db        (lkb)
   );

   always_comb begin
      n         = q;
      mult_upd  = 1'b0;
      integ_upd = 1'b0;
      n.ref_s   = {q.ref_s[0], i_ref_present};
      n.iv_s    = {q.iv_s[0], i_integ_valid};
      n.ld      = 1'b0;
      n.rvalid  = i_reg_rd;
      n.tick    = 1'b0;
      // slow enable for the debouncers
      if (q.div == 16'(TICK_CYCLES - 1)) begin
         n.div  = 16'h0000;
         n.tick = 1'b1;
      end else begin
         n.div = q.div + 16'h0001;
      end

      if (i_reg_wr) begin
         case (i_reg_addr)
            `FSC_CTRL_ADR: begin
               n.en     = i_reg_wdata[`FSC_CTRL_EN];
               n.fr     = i_reg_wdata[`FSC_CTRL_FR];
               mult_upd = i_reg_wdata[`FSC_CTRL_UPD];
            end
            `FSC_NMUL_ADR: begin
               n.n_sh = i_reg_wdata;
            end
            `FSC_THETA_ADR: begin
               n.th_sh = i_reg_wdata;
            end
            `FSC_LAMBDA_ADR: begin
               n.lam = i_reg_wdata;
            end
            `FSC_SYNC_ADR: begin
               n.sync_en = i_reg_wdata[0];
            end
            `FSC_FRC_ADR: begin
               n.frc = i_reg_wdata;
            end
            `FSC_INTEG_ADR: begin
               integ_upd = i_reg_wdata[`FSC_INTEG_UPD];
            end
            `FSC_SS_ADR: begin
               n.ss_mode = fsc_pkg::fsc_ss_t'(i_reg_wdata[1:0]);
               n.ss_amp  = i_reg_wdata[7:4];
               n.ss_freq = i_reg_wdata[11:8];
            end
            `FSC_GPIO_ADR: begin
               n.gp_sel = fsc_pkg::fsc_gp_t'(i_reg_wdata[1:0]);
            end
            `FSC_SRC_ADR: begin
               // reserved codes leave the previous source in place
               if (src_ok(i_reg_wdata[3:0])) begin
                  n.src = i_reg_wdata[3:0];
               end
            end
            `FSC_TUNE_ADR: begin
               n.gain = i_reg_wdata[5:2];
               n.bw   = i_reg_wdata[`FSC_TUNE_BW];
            end
            default: begin
            end
         endcase
      end

      // running loop sees new multipliers only on the strobe
      if (!n.en || mult_upd) begin
         n.n_eff  = n.n_sh;
         n.th_eff = n.th_sh;
      end

      case (q.st)
         fsc_pkg::FSC_IDLE: begin
            if (n.en) begin
               n.ran = 1'b1;
               if (n.fr) begin
                  n.st = fsc_pkg::FSC_FREE;
                  // never ran: start from the forced reset value
                  if (!q.ran) begin
                     n.ld     = 1'b1;
                     n.ld_val = `FSC_FRC_RST;
                  end
               end else begin
                  n.st = fsc_pkg::FSC_REF;
               end
            end
         end
         fsc_pkg::FSC_REF: begin
            if (!n.en) begin
               n.st = fsc_pkg::FSC_IDLE;
            end else if (n.fr) begin
               // integrator kept as is, so frequency holds
               n.st = fsc_pkg::FSC_FREE;
            end
         end
         fsc_pkg::FSC_FREE: begin
            if (!n.en) begin
               n.st = fsc_pkg::FSC_IDLE;
            end else if (!n.fr) begin
               n.st = fsc_pkg::FSC_REF;
            end else if (integ_upd) begin
               n.ld     = 1'b1;
               n.ld_val = n.frc;
            end
         end
         default: begin
            n.st = fsc_pkg::FSC_IDLE;
         end
      endcase

      n.rdata = 16'h0000;
      if (i_reg_rd) begin
         case (i_reg_addr)
            `FSC_CTRL_ADR: begin
               n.rdata = {14'h0000, q.fr, q.en};
            end
            `FSC_NMUL_ADR: begin
               n.rdata = q.n_sh;
            end
            `FSC_THETA_ADR: begin
               n.rdata = q.th_sh;
            end
            `FSC_LAMBDA_ADR: begin
               n.rdata = q.lam;
            end
            `FSC_SYNC_ADR: begin
               n.rdata = {15'h0000, q.sync_en};
            end
            `FSC_FRC_ADR: begin
               n.rdata = q.frc;
            end
            `FSC_INTEG_ADR: begin
               // strobe bit always reads zero
               n.rdata = {14'h0000, q.iv_s[1] && q.fr, 1'b0};
            end
            `FSC_INTEG_RB_ADR: begin
               // raw live word; software qualifies it by the valid bit
               n.rdata = i_integ_live;
            end
            `FSC_SS_ADR: begin
               n.rdata = {4'h0, q.ss_freq, q.ss_amp, 2'h0, q.ss_mode};
            end
            `FSC_GPIO_ADR: begin
               n.rdata = {14'h0000, q.gp_sel};
            end
            `FSC_STAT_ADR: begin
               n.rdata = {12'h000, q.st == fsc_pkg::FSC_FREE,
                          o_feedback_on, lkb.clean, okb.clean};
            end
            `FSC_SRC_ADR: begin
               n.rdata = {12'h000, q.src};
            end
            `FSC_TUNE_ADR: begin
               n.rdata = {10'h000, q.gain, 1'b0, q.bw};
            end
            default: begin
               n.rdata = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q         <= '0;
         q.st      <= fsc_pkg::FSC_IDLE;
         q.frc     <= `FSC_FRC_RST;
         q.src     <= `FSC_SRC_RST;
         q.gain    <= `FSC_GAIN_RST;
         q.bw      <= `FSC_BW_RST;
         q.ss_mode <= fsc_pkg::FSC_SS_OFF;
         q.gp_sel  <= fsc_pkg::FSC_GP_CLKOK;
      end else begin
         q <= n;
      end
   end

   assign o_reg_rdata   = q.rdata;
   assign o_reg_rvalid  = q.rvalid;
   assign o_loop_enable = q.en;
   // correction only when referenced and a reference is seen
   assign o_feedback_on = (q.st == fsc_pkg::FSC_REF)
                          && q.ref_s[1];
   assign o_integ_load  = q.ld;
   assign o_integ_value = q.ld_val;
   assign o_int_mult    = q.n_eff;
   assign o_frac_num    = q.th_eff;
   // fixed 65536 denominator replaces the register under sync
   assign o_frac_den    = q.sync_en ? `FSC_SYNC_DEN
                                    : {1'b0, q.lam};
   assign o_sync_enable = q.sync_en;
   assign o_sync_src    = q.src;
   assign o_sync_gain   = gain_dec;
   assign o_sync_narrow_bw = q.bw;
   assign o_ss_mode     = q.ss_mode;
   assign o_ss_amp      = q.ss_amp;
   assign o_ss_freq     = q.ss_freq;
   assign o_clk_ok_db   = okb.clean;
   assign o_lock_db     = lkb.clean;

   // raw path on purpose: pin status must work with no clock
   always_comb begin
      case (q.gp_sel)
         fsc_pkg::FSC_GP_CLKOK: begin
            gpio_mux = i_loop_clk_ok;
         end
         fsc_pkg::FSC_GP_LOCK: begin
            gpio_mux = i_loop_lock;
         end
         fsc_pkg::FSC_GP_CLK: begin
            gpio_mux = i_loop_clk;
         end
         default: begin
            gpio_mux = 1'b0;
         end
      endcase
   end

   // table form keeps the saturation at 256 in plain sight
   always_comb begin
      case (q.gain)
         4'h0:    gain_dec = 9'h001;
         4'h1:    gain_dec = 9'h002;
         4'h2:    gain_dec = 9'h004;
         4'h3:    gain_dec = 9'h008;
         4'h4:    gain_dec = 9'h010;
         4'h5:    gain_dec = 9'h020;
         4'h6:    gain_dec = 9'h040;
         4'h7:    gain_dec = 9'h080;
         default: gain_dec = 9'h100;
      endcase
   end

   assign o_gpio_out = gpio_mux;
endmodule : fsc_ctrl

// *** verification/fsc_ctrl_assertions.sv ***
`timescale 1ns/100ps
module fsc_ctrl_assertions #(
   parameter int TICK_CYCLES = 4,
   parameter int DB_TICKS    = 2
)(
   input wire logic        i_clock,
   input wire logic        i_sys_rst,
   input wire logic        i_reg_wr,
   input wire logic [15:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic        i_ref_present,
   input wire logic        i_slow_clk_on,
   input wire logic        o_loop_enable,
   input wire logic        o_feedback_on,
   input wire logic        o_integ_load,
   input wire logic [15:0] o_int_mult,
   input wire logic [16:0] o_frac_den,
   input wire logic        o_sync_enable,
   input wire logic [3:0]  o_sync_src,
   input wire logic [8:0]  o_sync_gain,
   input wire logic        o_sync_narrow_bw,
   input wire logic        o_clk_ok_db,
   input wire logic        o_lock_db
);
   logic [15:0] src_mask;
   // one bit per legal source code
   assign src_mask = 16'h7733 >> i_reg_wdata[3:0];
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);
   sequence s_tune_wr;
      i_reg_wr && i_reg_addr == 16'h01A7;
   endsequence
   sequence s_sync_on;
      i_reg_wr && i_reg_addr == 16'h0174 && i_reg_wdata[0];
   endsequence
   a_gain_decode: assert property (s_tune_wr |=> o_sync_gain ==
      ($past(i_reg_wdata[5]) ? 9'h100 : 9'h001 << $past(i_reg_wdata[4:2])))
      else $error("gain decode mismatch");
   a_bw_follow: assert property (
      s_tune_wr |=> o_sync_narrow_bw == $past(i_reg_wdata[0]))
      else $error("bandwidth bit mismatch");
   a_den_ignored: assert property (
      s_sync_on |-> ##2 o_sync_enable && o_frac_den == 17'h10000)
      else $error("denominator not overridden");
   a_src_keep: assert property (
      i_reg_wr && i_reg_addr == 16'h017B |=> o_sync_src == ($past(src_mask[0])
      ? $past(i_reg_wdata[3:0]) : $past(o_sync_src)))
      else $error("source select mismatch");
   a_fb_needs_en: assert property (o_feedback_on |-> o_loop_enable)
      else $error("feedback with loop off");
   a_ref_lost: assert property (!i_ref_present [*3] |-> !o_feedback_on)
      else $error("feedback without reference");
   a_mult_hold: assert property (o_loop_enable &&
      !(i_reg_wr && i_reg_addr == 16'h0170) |=> $stable(o_int_mult))
      else $error("multiplier changed without update");
   a_load_single: assert property (
      o_integ_load && !i_reg_wr |=> !o_integ_load)
      else $error("integrator load not a pulse");
   a_load_cause: assert property (o_integ_load |-> $past(i_reg_wr))
      else $error("integrator load without write");
   a_db_frozen: assert property (!i_slow_clk_on [*4] |=>
      $stable(o_clk_ok_db) && $stable(o_lock_db))
      else $error("debounced status moved without clock");
endmodule : fsc_ctrl_assertions

bind fsc_ctrl fsc_ctrl_assertions #(.TICK_CYCLES(TICK_CYCLES),
   .DB_TICKS(DB_TICKS)) chk_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
   .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .i_ref_present(i_ref_present), .i_slow_clk_on(i_slow_clk_on),
   .o_loop_enable(o_loop_enable), .o_feedback_on(o_feedback_on),
   .o_integ_load(o_integ_load), .o_int_mult(o_int_mult),
   .o_frac_den(o_frac_den), .o_sync_enable(o_sync_enable),
   .o_sync_src(o_sync_src), .o_sync_gain(o_sync_gain),
   .o_sync_narrow_bw(o_sync_narrow_bw), .o_clk_ok_db(o_clk_ok_db),
   .o_lock_db(o_lock_db));

// *** verification/fsc_loop_model.sv ***
`timescale 1ns/100ps
module fsc_loop_model #(
   parameter logic [15:0] LIVE_VAL = 16'hA5C3
)(
   input  wire logic        i_clock,
   input  wire logic        i_loop_enable,
   input  wire logic        i_feedback_on,
   output logic             o_clk_ok,
   output logic             o_lock,
   output logic             o_loop_clk,
   output logic             o_integ_valid,
   output logic [15:0]      o_integ_live
);
   logic [3:0] up_cnt = 4'h0;
   logic [3:0] lk_cnt = 4'h0;
   initial o_loop_clk = 1'b0;
   always @(posedge i_clock) begin
      up_cnt <= !i_loop_enable ? 4'h0
                : (up_cnt == 4'hF ? up_cnt : up_cnt + 4'h1);
      lk_cnt <= !i_feedback_on ? 4'h0
                : (lk_cnt == 4'hF ? lk_cnt : lk_cnt + 4'h1);
      o_integ_valid <= i_loop_enable;
   end
   assign o_clk_ok = (up_cnt == 4'hF);
   assign o_lock = (lk_cnt == 4'hF);
   // stale integrator shows inverted, never the last good value
   assign o_integ_live = o_integ_valid ? LIVE_VAL : ~LIVE_VAL;
   always #5 o_loop_clk = o_clk_ok ? ~o_loop_clk : 1'b0;
endmodule : fsc_loop_model

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
   logic i_clock = 0, i_sys_rst = 1, i_reg_wr = 0, i_reg_rd = 0;
   logic [15:0] i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata;
   logic [15:0] o_integ_value, o_int_mult, o_frac_num, i_integ_live;
   logic i_ref_present = 0, i_slow_clk_on = 0, o_reg_rvalid, o_loop_enable;
   logic i_loop_clk_ok, i_loop_lock, i_loop_clk, i_integ_valid, o_gpio_out;
   logic o_feedback_on, o_integ_load, o_sync_enable, o_sync_narrow_bw;
   logic o_clk_ok_db, o_lock_db;
   logic [16:0] o_frac_den;
   logic [8:0] o_sync_gain;
   logic [3:0] o_sync_src, o_ss_amp, o_ss_freq, exp_src;
   logic [1:0] o_ss_mode;
   int num_errors = 0, total_checks = 0;
   fsc_ctrl #(.TICK_CYCLES(4), .DB_TICKS(2)) dut_u (.i_clock(i_clock),
      .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
      .i_ref_present(i_ref_present), .i_loop_clk_ok(i_loop_clk_ok),
      .i_loop_lock(i_loop_lock), .i_loop_clk(i_loop_clk),
      .i_integ_valid(i_integ_valid), .i_integ_live(i_integ_live),
      .i_slow_clk_on(i_slow_clk_on), .o_loop_enable(o_loop_enable),
      .o_feedback_on(o_feedback_on), .o_integ_load(o_integ_load),
      .o_integ_value(o_integ_value), .o_int_mult(o_int_mult),
      .o_frac_num(o_frac_num), .o_frac_den(o_frac_den),
      .o_sync_enable(o_sync_enable), .o_sync_src(o_sync_src),
      .o_sync_gain(o_sync_gain), .o_sync_narrow_bw(o_sync_narrow_bw),
      .o_ss_mode(o_ss_mode), .o_ss_amp(o_ss_amp), .o_ss_freq(o_ss_freq),
      .o_clk_ok_db(o_clk_ok_db), .o_lock_db(o_lock_db),
      .o_gpio_out(o_gpio_out));
   fsc_loop_model far_u (.i_clock(i_clock), .i_loop_enable(o_loop_enable),
      .i_feedback_on(o_feedback_on), .o_clk_ok(i_loop_clk_ok),
      .o_lock(i_loop_lock), .o_loop_clk(i_loop_clk),
      .o_integ_valid(i_integ_valid), .o_integ_live(i_integ_live));
   initial begin
      forever #2 i_clock = ~i_clock;
   end
   task automatic chk(input string nm, input logic [16:0] e,
                      input logic [16:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge i_clock);
      {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
      @(negedge i_clock);
      i_reg_wr = 0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [15:0] e,
                     input string nm);
      @(negedge i_clock);
      {i_reg_rd, i_reg_addr} = {1'b1, a};
      @(negedge i_clock);
      i_reg_rd = 0;
      chk("rvalid", 1, o_reg_rvalid);
      chk(nm, e, o_reg_rdata);
   endtask : rd
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   initial begin
      #40000;
      num_errors++;
      stop_test();
   end
   initial begin
      repeat (10) @(negedge i_clock);
      i_sys_rst = 0;
      chk("bw", 1, o_sync_narrow_bw);
      chk("gain", 1, o_sync_gain);
      rd(16'h01A7, 16'h0001, "tune");
      rd(16'h0175, 16'h0000, "frc");
      rd(16'h0100, 16'h0000, "unmapped");
      exp_src = 4'h0;
      for (int c = 0; c < 16; c++) begin
         wr(16'h01A7, {10'h000, c[3:0], 1'b0, c[0]});
         chk("gain", c > 7 ? 9'h100 : 9'h001 << c, o_sync_gain);
         chk("bw", c[0], o_sync_narrow_bw);
         wr(16'h017B, {12'h000, c[3:0]});
         exp_src = (16'h7733 >> c) & 1 ? c[3:0] : exp_src;
         chk("src", exp_src, o_sync_src);
      end
      for (int m = 0; m < 4; m++) begin
         wr(16'h0178, {4'h0, 4'hF - m[3:0], m[3:0] + 4'h1, 2'b00, m[1:0]});
         chk("ssm", m[1:0], o_ss_mode);
         chk("ssa", m[3:0] + 4'h1, o_ss_amp);
         chk("ssf", 4'hF - m[3:0], o_ss_freq);
      end
      $display("test fields done");
      wr(16'h0172, 16'h0018);
      wr(16'h0173, 16'h007D);
      chk("num", 16'h0018, o_frac_num);
      wr(16'h0174, 16'h0000);
      @(negedge i_clock);
      chk("den", 17'h0007D, o_frac_den);
      wr(16'h0174, 16'h0001);
      @(negedge i_clock);
      chk("den", 17'h10000, o_frac_den);
      wr(16'h0172, 16'h3127);
      wr(16'h0171, 16'h0008);
      @(negedge i_clock);
      chk("num", 16'h3127, o_frac_num);
      chk("int", 16'h0008, o_int_mult);
      wr(16'h0175, 16'h5A5A);
      i_ref_present = 1;
      wr(16'h0170, 16'h0003);
      chk("load", 1, o_integ_load);
      chk("ival", 16'h0000, o_integ_value);
      repeat (4) @(negedge i_clock);
      chk("fb", 0, o_feedback_on);
      wr(16'h0175, 16'h1234);
      wr(16'h0176, 16'h0001);
      chk("load", 1, o_integ_load);
      chk("ival", 16'h1234, o_integ_value);
      @(negedge i_clock);
      chk("load", 0, o_integ_load);
      rd(16'h0176, 16'h0002, "valid");
      rd(16'h0177, 16'hA5C3, "integ");
      wr(16'h0170, 16'h0001);
      wr(16'h0176, 16'h0001);
      chk("load", 0, o_integ_load);
      rd(16'h0176, 16'h0000, "valid");
      chk("fb", 1, o_feedback_on);
      $display("test free run done");
      wr(16'h0171, 16'h0009);
      repeat (2) @(negedge i_clock);
      chk("int", 16'h0008, o_int_mult);
      wr(16'h0170, 16'h0005);
      @(negedge i_clock);
      chk("int", 16'h0009, o_int_mult);
      i_ref_present = 0;
      repeat (4) @(negedge i_clock);
      chk("fb", 0, o_feedback_on);
      i_ref_present = 1;
      repeat (4) @(negedge i_clock);
      chk("fb", 1, o_feedback_on);
      wr(16'h0170, 16'h0003);
      chk("load", 0, o_integ_load);
      rd(16'h017A, 16'h0008, "status");
      wr(16'h0170, 16'h0001);
      repeat (40) @(negedge i_clock);
      chk("okdb", 0, o_clk_ok_db);
      i_slow_clk_on = 1;
      for (int k = 0; k < 100 && !(o_clk_ok_db && o_lock_db); k++)
         @(negedge i_clock);
      rd(16'h017A, 16'h0007, "status");
      $display("test loop done");
      for (int s = 0; s < 4; s++) begin
         wr(16'h0179, {14'h0000, s[1:0]});
         @(posedge i_loop_clk);
         #0.5;
         chk("gpio", s == 0 ? i_loop_clk_ok : s == 1 ? i_loop_lock :
            s == 2, o_gpio_out);
      end
      wr(16'h0179, 16'h0000);
      wr(16'h0170, 16'h0000);
      @(negedge i_clock);
      chk("gpio", 0, o_gpio_out);
      chk("okdb", 1, o_clk_ok_db);
      $display("test pins done");
      stop_test();
   end
endmodule : tb_top
